/* File: eeprom_access_params.svh */
// timing counts, bit positions and register selectors for the eeprom access block
`ifndef EEPROM_ACCESS_PARAMS_SVH
`define EEPROM_ACCESS_PARAMS_SVH
`define EE_SEL_ADDR_LO     2'h0
`define EE_SEL_ADDR_HI     2'h1
`define EE_SEL_DATA        2'h2
`define EE_SEL_CTRL        2'h3
`define EE_BIT_READ        0
`define EE_BIT_WRITE       1
`define EE_BIT_MWE         2
`define EE_BIT_RIE         3
`define EE_MWE_WINDOW      4
`define EE_WRITE_STALL     2
`define EE_READ_STALL      4
`define EE_WRITE_OSC_CYC   8448
`define EE_CLK_HZ          10000000
`define EE_OSC_HZ          1000000
`define EE_OSC_DIV         (`EE_CLK_HZ / `EE_OSC_HZ)
`define EE_ADDR_W          12
`endif

/* File: eeprom_access_pkg.sv */
// types shared by the eeprom access block
package eeprom_access_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_WRITE = 2'h1,
    ST_DONE  = 2'h3
  } wr_state_e;
  typedef struct packed {
    logic       we;
    logic       re;
    logic [1:0] sel;
    logic [7:0] wdata;
  } reg_req_s;
endpackage : eeprom_access_pkg

/* File: eeprom_array.sv */
// 4k x 8 byte array with registered read data
`timescale 1ns/1ps
module eeprom_array #(
  parameter int AW = 12                      // address width
) (
  input  wire logic          clk_i,          // cpu clock
  input  wire logic          wr_i,           // write strobe
  input  wire logic          rd_i,           // read strobe
  input  wire logic [AW-1:0] addr_i,         // byte address
  input  wire logic [7:0]    wdata_i,        // write byte
  output logic      [7:0]    rdata_o         // registered read byte
);
  logic [7:0] mem_q [0:(1<<AW)-1];           // storage, no reset: nonvolatile
  logic [7:0] rdata_q;                       // read register

  // array write and registered read
  always_ff @(posedge clk_i) begin
    if (wr_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    if (rd_i) begin
      rdata_q <= mem_q[addr_i];
    end
  end
  assign rdata_o = rdata_q;
endmodule : eeprom_array

/* File: eeprom_access_control.sv */
// processor-side control of single byte eeprom reads and writes
// Operation
// - data register carries write byte and read byte
// - control bits seven to four read zero
// - ready irq while enabled and strobe clear
// - strobe only starts within four-cycle window
// - master enable self-clears after four cycles
// - strobe with master enable stores data
// - no write while flash self-programming busy
// - hardware clears strobe after programming time
// - stall cpu two cycles after write
// - read strobe fetches byte, stall four
// - ignore reads, address changes during write
// - write lasts 8448 one-megahertz oscillator cycles
// - write in progress survives reset
// - twelve-bit address, upper four read zero
`timescale 1ns/1ps
`include "eeprom_access_params.svh"
module eeprom_access_control
  import eeprom_access_pkg::*;
#(
  parameter int WRITE_OSC_CYC = `EE_WRITE_OSC_CYC, // oscillator cycles per write
  parameter int OSC_DIV       = `EE_OSC_DIV        // cpu clocks per oscillator cycle
) (
  input  wire logic       clk_i,             // cpu clock, 10 mhz
  input  wire logic       rst_n_i,           // synchronous reset, active low
  input  wire reg_req_s   req_i,             // register access from cpu
  input  wire logic       global_irq_en_i,   // i-bit of cpu_status_word
  input  wire logic       self_program_busy_i, // flash self-programming active
  output logic [7:0]      rdata_o,           // read data for selected register
  output logic            stall_o,           // halt cpu
  output logic            ready_irq_o        // ready interrupt request level
);
  localparam int AW = `EE_ADDR_W;            // address width
  localparam logic [2:0] MWE_CNT  = 3'(`EE_MWE_WINDOW);
  localparam logic [2:0] WSTALL   = 3'(`EE_WRITE_STALL);
  localparam logic [2:0] RSTALL   = 3'(`EE_READ_STALL);

  logic [AW-1:0] eeprom_address_q, eeprom_address_d; // byte address
  logic [7:0]    eeprom_data_q, eeprom_data_d;        // data register
  logic          rie_q, rie_d;                        // ready irq enable
  logic [2:0]    mwe_q, mwe_d;                        // master enable cycles left
  logic [2:0]    stall_q, stall_d;                    // stall cycles left
  logic          rd_pend_q, rd_pend_d;                // array read in flight
  wr_state_e     st_q, st_d;                          // write sequencer
  logic [15:0]   osc_q, osc_d;                        // oscillator cycles done
  logic [7:0]    div_q, div_d;                        // 1 mhz tick divider
  logic          tick;                                // one oscillator cycle
  logic          busy;                                // write in progress
  logic          arr_wr, arr_rd;                      // array strobes
  logic [7:0]    arr_rdata;                           // array read byte

  // decode a write to one register selector
  function automatic logic wr_to(input reg_req_s r, input logic [1:0] s);
    return r.we && (r.sel == s);
  endfunction : wr_to

  assign busy = (st_q != ST_IDLE);
  assign tick = (div_q == 8'(OSC_DIV - 1));

  // accept a write strobe only inside the window and with flash idle
  assign arr_wr = wr_to(req_i, `EE_SEL_CTRL) && req_i.wdata[`EE_BIT_WRITE]
                  && (mwe_q != 3'h0) && !busy && !self_program_busy_i;
  assign arr_rd = wr_to(req_i, `EE_SEL_CTRL) && req_i.wdata[`EE_BIT_READ]
                  && !busy;

  eeprom_array #(.AW(AW)) u_array (
    .clk_i   (clk_i),
    .wr_i    (arr_wr),
    .rd_i    (arr_rd),
    .addr_i  (eeprom_address_q),
    .wdata_i (eeprom_data_q),
    .rdata_o (arr_rdata)
  );

  // register file and strobe bookkeeping
  always_comb begin
    eeprom_address_d = eeprom_address_q;
    eeprom_data_d    = eeprom_data_q;
    rie_d            = rie_q;
    rd_pend_d        = arr_rd;
    mwe_d            = (mwe_q != 3'h0) ? mwe_q - 3'h1 : 3'h0;
    stall_d          = (stall_q != 3'h0) ? stall_q - 3'h1 : 3'h0;
    if (!busy && wr_to(req_i, `EE_SEL_ADDR_LO)) begin
      eeprom_address_d[7:0] = req_i.wdata;
    end
    if (!busy && wr_to(req_i, `EE_SEL_ADDR_HI)) begin
      eeprom_address_d[AW-1:8] = req_i.wdata[AW-9:0];
    end
    if (wr_to(req_i, `EE_SEL_DATA)) begin
      eeprom_data_d = req_i.wdata;
    end
    if (rd_pend_q) begin
      eeprom_data_d = arr_rdata;
    end
    if (wr_to(req_i, `EE_SEL_CTRL)) begin
      rie_d = req_i.wdata[`EE_BIT_RIE];
      // a write that sets master enable while strobe zero opens the window
      if (req_i.wdata[`EE_BIT_MWE] && !req_i.wdata[`EE_BIT_WRITE]) begin
        mwe_d = MWE_CNT;
      end
    end
    if (arr_wr) begin
      mwe_d   = 3'h0;                                                 // window used up
      stall_d = WSTALL;
    end
    if (arr_rd) begin
      stall_d = RSTALL;
    end
  end

  // write timing sequencer, driven by the 1 mhz enable
  always_comb begin
    st_d  = st_q;
    osc_d = osc_q;
    div_d = tick ? 8'h00 : div_q + 8'h01;
    case (st_q)
      ST_IDLE: begin
        osc_d = 16'h0000;
        div_d = 8'h00;
        if (arr_wr) begin
          st_d = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (tick) begin
          osc_d = osc_q + 16'h0001;
          if (osc_q == 16'(WRITE_OSC_CYC - 1)) begin
            st_d = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // registers; the write sequencer ignores reset so writes complete
  always_ff @(posedge clk_i) begin
    st_q  <= st_d;
    osc_q <= osc_d;
    div_q <= div_d;
    if (!rst_n_i) begin
      eeprom_data_q <= 8'h00;
      rie_q         <= 1'b0;
      mwe_q         <= 3'h0;
      stall_q       <= 3'h0;
      rd_pend_q     <= 1'b0;
    end else begin
      eeprom_data_q <= eeprom_data_d;
      rie_q         <= rie_d;
      mwe_q         <= mwe_d;
      stall_q       <= stall_d;
      rd_pend_q     <= rd_pend_d;
    end
    eeprom_address_q <= eeprom_address_d;                             // undefined at reset
  end

  // read mux; reserved bits come back as zero
  always_comb begin
    case (req_i.sel)
      `EE_SEL_ADDR_LO: rdata_o = eeprom_address_q[7:0];
      `EE_SEL_ADDR_HI: rdata_o = {4'h0, eeprom_address_q[AW-1:8]};
      `EE_SEL_DATA:    rdata_o = eeprom_data_q;
      `EE_SEL_CTRL:    rdata_o = {4'h0, rie_q, (mwe_q != 3'h0), busy, 1'b0};
      default:         rdata_o = 8'h00;
    endcase
  end

  assign stall_o     = (stall_q != 3'h0) || arr_wr || arr_rd;
  assign ready_irq_o = rie_q && global_irq_en_i && !busy;

  // master enable lasts exactly four cycles then clears
  a_mwe_timeout: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (mwe_q == MWE_CNT) |-> ##4 (mwe_q == 3'h0)) else $error("mwe not cleared");
  // no write start without open window
  a_strobe_window: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_q == ST_IDLE && st_d == ST_WRITE) |-> (mwe_q != 3'h0)) else $error("bad start");
  // an accepted strobe always launches the timed write
  a_strobe_stores: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    arr_wr |=> busy) else $error("write not started");
  // flash programming blocks the array write strobe
  a_flash_lock: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    self_program_busy_i |-> !arr_wr) else $error("write during flash");
  // write stall: strobe cycle plus two counted cycles
  sequence s_write_stall;
    stall_o [*3] ##1 !stall_o;
  endsequence
  a_wr_stall_two: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    arr_wr |-> s_write_stall) else $error("write stall");
  // read stall: strobe cycle plus four counted cycles
  sequence s_read_stall;
    stall_o [*5] ##1 !stall_o;
  endsequence
  a_rd_stall_four: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    arr_rd |-> s_read_stall) else $error("read stall");
  // the fetched byte lands in the data register two edges later
  a_rd_fetch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    arr_rd |=> ##1 (eeprom_data_q == $past(arr_rdata))) else $error("read data");
  // a running write freezes the address and refuses reads
  a_busy_ignore: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    busy |-> !arr_rd && $stable(eeprom_address_q)) else $error("access while busy");
  // reserved control bits never read back as one
  a_reserved_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (req_i.sel == `EE_SEL_CTRL) |-> (rdata_o[7:4] == 4'h0)) else $error("reserved");
  // the request never shows while the strobe bit reads one
  a_irq_ready: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ready_irq_o |-> (rdata_o[`EE_BIT_WRITE] == 1'b0 || req_i.sel != `EE_SEL_CTRL))
    else $error("irq while busy");
  // either enable low keeps the request quiet; both high and idle raise it
  a_irq_gated: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!rie_q || !global_irq_en_i) |-> !ready_irq_o) else $error("irq not gated");
  a_irq_raised: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rie_q && global_irq_en_i && st_q == ST_IDLE) |-> ready_irq_o) else $error("irq missing");
  // last oscillator cycle hands the write over to the done step
  a_write_length: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_q == ST_WRITE && tick && osc_q == 16'(WRITE_OSC_CYC - 1)) |=> (st_q == ST_DONE))
    else $error("write length");
  // the done step always returns the strobe bit to zero
  a_write_ends: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_q == ST_DONE) |=> !busy) else $error("strobe stuck");
endmodule : eeprom_access_control

/* File: tb_eeprom_access_control.sv */
// self-checking bench for the eeprom access control block
`timescale 1ns/1ps
`include "eeprom_access_params.svh"
module tb_eeprom_access_control;
  import eeprom_access_pkg::*;
  typedef struct packed {
    logic [1:0] kind;                  // 0 read data, 1 stall, 2 ready irq
    logic [7:0] val;                   // expected value
  } note_s;
  logic        clk_i    = 1'b0;        // cpu clock
  logic        rst_n_i  = 1'b0;        // synchronous reset
  reg_req_s    req_i    = '0;          // register request
  logic        gie      = 1'b0;        // global irq enable
  logic        spm_busy = 1'b0;        // flash programming busy
  logic [7:0]  rdata;                  // register read data
  logic        stall;                  // cpu halt
  logic        irq;                    // ready irq level
  note_s       note_q[$];              // expectations in issue order
  int          error_cnt = 0;          // mismatches
  int          n_checks  = 0;          // comparisons
  int          seed      = 32'h94b4;   // fixed seed
  logic [7:0]  byte_v;                 // random data byte
  logic [11:0] addr_v;                 // random address
  // short write time keeps the run small: 8 x 2 clocks per write
  localparam int WR_OSC   = 8;                        // oscillator cycles per write
  localparam int OSC_DV   = 2;                        // clocks per oscillator cycle
  localparam int BUSY_CYC = WR_OSC * OSC_DV + 1;      // cycles the strobe bit reads one
  eeprom_access_control #(.WRITE_OSC_CYC(WR_OSC), .OSC_DIV(OSC_DV)) i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .global_irq_en_i(gie),
    .self_program_busy_i(spm_busy), .rdata_o(rdata), .stall_o(stall), .ready_irq_o(irq));
  always #50 clk_i = ~clk_i;
  // one register request per cycle, changed on the rising edge
  task automatic acc(input logic we, input logic [1:0] sel, input logic [7:0] wd);
    @(posedge clk_i);
    req_i <= '{we: we, re: 1'b0, sel: sel, wdata: wd};
  endtask : acc
  task automatic note(input logic [1:0] k, input logic [7:0] v);
    note_q.push_back('{kind: k, val: v});
  endtask : note
  // outputs are settled mid-cycle, so every pending note is judged there
  always @(negedge clk_i) begin : monitor
    note_s      n;
    logic [7:0] seen;
    while (note_q.size() > 0) begin
      n = note_q.pop_front();
      seen = (n.kind == 2'h0) ? rdata : (n.kind == 2'h1) ? {7'h00, stall} : {7'h00, irq};
      n_checks++;
      if (seen !== n.val) begin
        error_cnt++;
        $display("[FAIL] %s expected %h seen %h",
                 (n.kind == 2'h0) ? "rdata_o" : (n.kind == 2'h1) ? "stall_o" : "ready_irq_o",
                 n.val, seen);
      end
    end
  end
  // full write; the strobe lands on the last cycle of the enable window
  task automatic write_seq(input logic [11:0] a, input logic [7:0] d);
    acc(1'b1, `EE_SEL_ADDR_LO, a[7:0]);
    acc(1'b1, `EE_SEL_ADDR_HI, {4'h0, a[11:8]});
    acc(1'b1, `EE_SEL_DATA, d);
    acc(1'b1, `EE_SEL_CTRL, 8'h04);
    for (int i = 0; i < 3; i++) begin
      acc(1'b0, `EE_SEL_CTRL, 8'h00);
      note(2'h0, 8'h04);
    end
    acc(1'b1, `EE_SEL_CTRL, 8'h02);
    note(2'h1, 8'h01);
    acc(1'b0, `EE_SEL_CTRL, 8'h00);
    note(2'h1, 8'h01);
    acc(1'b0, `EE_SEL_CTRL, 8'h00);
    note(2'h0, 8'h02);
    acc(1'b0, `EE_SEL_CTRL, 8'h00);
    note(2'h1, 8'h00);
  endtask : write_seq
  // bounded poll of the busy bit; a hang here is a mismatch
  // exp_n is the number of polls that must still see the write running
  task automatic wait_idle(input int exp_n);
    int n;
    n = 0;
    for (int i = 0; i < 60; i++) begin
      acc(1'b0, `EE_SEL_CTRL, 8'h00);
      @(negedge clk_i);
      if (rdata[1] === 1'b0) begin
        n_checks++;
        if (n != exp_n) begin
          error_cnt++;
          $display("[FAIL] busy_cycles expected %0d seen %0d", exp_n, n);
        end
        return;
      end
      n++;
    end
    error_cnt++;
    $display("[FAIL] write busy expected 0 seen 1");
  endtask : wait_idle
  // read strobe stalls request cycle plus four, then data holds the byte
  task automatic read_chk(input logic [11:0] a, input logic [7:0] d);
    acc(1'b1, `EE_SEL_ADDR_LO, a[7:0]);
    acc(1'b1, `EE_SEL_ADDR_HI, {4'h0, a[11:8]});
    acc(1'b1, `EE_SEL_DATA, ~d);
    acc(1'b1, `EE_SEL_CTRL, 8'h01);
    note(2'h1, 8'h01);
    repeat (4) begin
      acc(1'b0, `EE_SEL_DATA, 8'h00);
      note(2'h1, 8'h01);
    end
    acc(1'b0, `EE_SEL_DATA, 8'h00);
    note(2'h1, 8'h00);
    note(2'h0, d);
  endtask : read_chk
  task automatic conclude();
    @(negedge clk_i);
    #1;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  initial begin : watchdog
    #(100 * 4000);
    error_cnt++;
    $display("[FAIL] watchdog expected done seen running");
    conclude();
  end
  initial begin : main
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    acc(1'b0, `EE_SEL_CTRL, 8'h00);
    note(2'h0, 8'h00);
    acc(1'b1, `EE_SEL_CTRL, 8'hf0);
    acc(1'b0, `EE_SEL_CTRL, 8'h00);
    note(2'h0, 8'h00);
    acc(1'b1, `EE_SEL_ADDR_HI, 8'hff);
    acc(1'b0, `EE_SEL_ADDR_HI, 8'h00);
    note(2'h0, 8'h0f);
    byte_v = 8'($random(seed));
    addr_v = 12'($random(seed));
    write_seq(addr_v, byte_v);
    gie <= 1'b1;
    acc(1'b1, `EE_SEL_ADDR_LO, ~addr_v[7:0]);
    acc(1'b0, `EE_SEL_ADDR_LO, 8'h00);
    note(2'h0, addr_v[7:0]);
    acc(1'b1, `EE_SEL_CTRL, 8'h08);
    acc(1'b0, `EE_SEL_CTRL, 8'h00);
    note(2'h2, 8'h00);
    wait_idle(BUSY_CYC - 7);
    acc(1'b0, `EE_SEL_CTRL, 8'h00);
    note(2'h2, 8'h01);
    note(2'h0, 8'h08);
    acc(1'b0, `EE_SEL_CTRL, 8'h00);
    gie <= 1'b0;
    note(2'h2, 8'h00);
    read_chk(addr_v, byte_v);
    acc(1'b1, `EE_SEL_CTRL, 8'h02);
    acc(1'b0, `EE_SEL_CTRL, 8'h00);
    note(2'h0, 8'h00);
    acc(1'b1, `EE_SEL_CTRL, 8'h04);
    repeat (4) acc(1'b0, `EE_SEL_CTRL, 8'h00);
    acc(1'b1, `EE_SEL_CTRL, 8'h02);
    note(2'h0, 8'h00);
    note(2'h1, 8'h00);
    acc(1'b0, `EE_SEL_CTRL, 8'h00);
    note(2'h0, 8'h00);
    spm_busy <= 1'b1;
    acc(1'b1, `EE_SEL_CTRL, 8'h04);
    acc(1'b1, `EE_SEL_CTRL, 8'h02);
    note(2'h1, 8'h00);
    acc(1'b0, `EE_SEL_CTRL, 8'h00);
    note(2'h0, 8'h04);
    spm_busy <= 1'b0;
    write_seq(~addr_v, ~byte_v);
    rst_n_i <= 1'b0;
    repeat (2) acc(1'b0, `EE_SEL_CTRL, 8'h00);
    rst_n_i <= 1'b1;
    acc(1'b0, `EE_SEL_CTRL, 8'h00);
    note(2'h0, 8'h02);
    wait_idle(BUSY_CYC - 6);
    read_chk(~addr_v, ~byte_v);
    conclude();
  end
endmodule : tb_eeprom_access_control
